/* File: common/smt_pkg.sv */
/*
 * Constants and types of the sixteen-bit multimode timer channel:
 * register offsets, control field positions, reset values, modes.
 * Assumes a 32-bit APB with byte addresses, one register per word.
 */
package smt_pkg;

    // Register byte offsets
    localparam logic [7:0] SMT_OFS_CTRL  = 8'h00;
    localparam logic [7:0] SMT_OFS_TIMER = 8'h04;
    localparam logic [7:0] SMT_OFS_STAT  = 8'h08;

    // Control register field positions
    localparam int SMT_CTL_RUN     = 0;   // Run enable
    localparam int SMT_CTL_MODE    = 1;   // Two bits, operating mode
    localparam int SMT_CTL_SRC     = 3;   // Two bits, internal count source
    localparam int SMT_CTL_GATE    = 5;   // Two bits, gate select
    localparam int SMT_CTL_PULSE   = 7;   // Pulse output enable
    localparam int SMT_CTL_EVSRC   = 8;   // Two bits, event source
    localparam int SMT_CTL_FREERUN = 10;  // Free-run type
    localparam int SMT_CTL_TWOPH   = 11;  // Two-phase processing
    localparam int SMT_CTL_UP      = 12;  // Up/down flag, 1 counts up
    localparam int SMT_CTL_DIRPIN  = 13;  // Direction taken from output pin
    localparam int SMT_CTL_PWM8    = 14;  // 8-bit variable-period PWM
    localparam int SMT_CTL_TRIG    = 15;  // Two bits, start trigger
    localparam int SMT_CTL_SWTRIG  = 17;  // Write-only software trigger
    localparam int SMT_CTL_WIDTH   = 17;  // Stored control bits

    // Status register field positions
    localparam int SMT_ST_IRQ    = 0;     // Interrupt request, write 1 clears
    localparam int SMT_ST_OUT    = 1;     // Output pin level
    localparam int SMT_ST_ACTIVE = 2;     // One-shot or PWM running

    // Reset values and prescaler figures
    localparam logic [15:0] SMT_TIMER_RST = 16'h0000;
    localparam logic [15:0] SMT_CNT_MAX   = 16'hFFFF;
    localparam logic [15:0] SMT_PWM16_TOP = 16'hFFFE;
    localparam logic [4:0]  SMT_PRE_RST   = 5'h00;
    localparam logic [2:0]  SMT_DIV8_LAST = 3'h7;
    localparam logic [4:0]  SMT_DIV32_LAST = 5'h1F;

    typedef enum logic [1:0] {SMT_MODE_TIMER, SMT_MODE_EVENT,
                              SMT_MODE_ONESHOT, SMT_MODE_PWM} smt_mode_t;
    typedef enum logic [1:0] {SMT_SRC_DIV1, SMT_SRC_DIV8,
                              SMT_SRC_DIV32, SMT_SRC_SUB32} smt_src_t;
    typedef enum logic [1:0] {SMT_GATE_OFF, SMT_GATE_RSVD,
                              SMT_GATE_LOW, SMT_GATE_HIGH} smt_gate_t;
    typedef enum logic [1:0] {SMT_EV_FALL, SMT_EV_RISE,
                              SMT_EV_OVF, SMT_EV_OVF2} smt_evsrc_t;
    typedef enum logic [1:0] {SMT_TRIG_SW, SMT_TRIG_PIN,
                              SMT_TRIG_OVF, SMT_TRIG_OVF2} smt_trig_t;

    // Whole state of the channel
    typedef struct packed {
        logic [SMT_CTL_WIDTH-1:0] ctrl;     // Stored control bits
        logic [15:0]              counter;  // Live count
        logic [15:0]              reload;   // Reload value
        logic                     irq;      // Sticky request
        logic                     outLvl;   // Output pin level
        logic                     active;   // One-shot or PWM running
        logic                     prevIn;   // Input pin, last cycle
        logic [4:0]               preMain;  // Main clock prescaler
        logic [4:0]               preSub;   // Secondary clock prescaler
        logic [31:0]              rdata;    // Read data
    } smt_state_t;

endpackage

/* File: rtl/smt_timer.sv */
/*
 * Sixteen-bit multimode timer channel with an APB register slave.
 * Assumes pins and the secondary clock tick are synchronous to sys_clk;
 * the secondary clock arrives as a one-cycle enable pulse.
 */
// Local design decisions: the address map and the APB interface to the registers.
// What this block does
// R1: Sixteen-bit counter and sixteen-bit reload value
// R2: One of four modes at a time
// R3: Timer mode counts internal source, toggle or gate
// R4: Gated counting only at selected input level
// R5: Event mode counts pin pulses or overflows
// R6: Free-run type skips reload on wrap
// R7: Two-phase input sets count direction
// R8: One-shot starts on selected trigger, stops at zero
// R9: PWM repeats pulses, 16-bit or 8-bit period
// R10: Source is main divided 1/8/32 or sub/32
// R11: Timer ratio is value plus one, 8-bit PWM period is low byte plus one
// R12: Event ratio value+1 down, FFFF-value+1 up
// R13: One-shot ratio equals programmed value
// R14: Ratio reached raises request, pin toggles
// R15: Timer read returns live count, 16-bit
// R16: Write while running sets reload only
// R17: Software sets port direction to input
// R18: Output pin is input in event mode
// R19: Run flag set counts down per tick
// R20: Underflow reloads, continues, sets request bit
// R21: Run flag cleared freezes the counter
// R22: High gate counts while pin high only
// R23: Pulse output low when run cleared
// R24: Direction change acts from next edge
// R25: Request bit sticky until cleared
`timescale 1ns/1ps
module smt_timer
    import smt_pkg::*;
(
    input  wire logic        sys_clk,       // 25 MHz clock
    input  wire logic        arst_n,        // Asynchronous reset, active low
    input  wire logic        psel,          // APB select
    input  wire logic        penable,       // APB access phase
    input  wire logic        pwrite,        // APB write
    input  wire logic [7:0]  paddr,         // APB byte address
    input  wire logic [31:0] pwdata,        // APB write data
    input  wire logic [3:0]  pstrb,         // APB byte strobes
    output logic      [31:0] prdata,        // APB read data
    output logic             pready,        // APB ready
    output logic             pslverr,       // APB error
    input  wire logic        subClkTick,    // Secondary clock enable pulse
    input  wire logic        otherOvf,      // Overflow of another timer
    input  wire logic        irqAck,        // Interrupt acknowledge pulse
    input  wire logic        timerInputPin, // Timer input pin
    input  wire logic        tmrOutPinIn,   // Output pin, input side
    output logic             tmrOutPinOut,  // Output pin, driven level
    output logic             tmrOutPinOeN,  // Output pin enable, low drives
    output logic             irqReq         // Interrupt request bit
);

    smt_state_t st;          // Registered state
    smt_state_t next_st;     // Next state
    smt_mode_t  mode;        // Decoded mode
    smt_src_t   src;         // Decoded count source
    smt_gate_t  gate;        // Decoded gate select
    smt_evsrc_t evSrc;       // Decoded event source
    smt_trig_t  trig;        // Decoded start trigger
    logic       run;         // Run flag
    logic       pulseEn;     // Pulse output enable
    logic       intTick;     // Internal count source tick
    logic       evTick;      // Event count tick
    logic       countUp;     // Event direction
    logic       gateOk;      // Gate lets counting through
    logic       startTrig;   // One-shot or PWM trigger
    logic       inFall;      // Input pin falling edge
    logic       inRise;      // Input pin rising edge
    logic       apbAcc;      // APB access phase
    logic       wrCtrl;      // Control write
    logic       wrTimer;     // Accepted timer write
    logic       wrStat;      // Status write
    logic       badAddr;     // Unmapped address
    logic       badStrb;     // Timer write not 16 bits wide
    logic       irqEvt;      // Overflow or underflow this cycle
    logic [15:0] pwmTop;     // Last phase of PWM period

    // PWM level for a given phase
    function automatic logic pwmLevel(input logic [15:0] ph, input logic [15:0] rl,
                                      input logic w8);
        if (w8) begin
            return ph[7:0] < rl[15:8];
        end
        return ph < rl;
    endfunction

    // Field decode of control register
    always_comb begin
        run     = st.ctrl[SMT_CTL_RUN];
        mode    = smt_mode_t'(st.ctrl[SMT_CTL_MODE +: 2]);   // [R2]
        src     = smt_src_t'(st.ctrl[SMT_CTL_SRC +: 2]);
        gate    = smt_gate_t'(st.ctrl[SMT_CTL_GATE +: 2]);
        evSrc   = smt_evsrc_t'(st.ctrl[SMT_CTL_EVSRC +: 2]);
        trig    = smt_trig_t'(st.ctrl[SMT_CTL_TRIG +: 2]);
        pulseEn = st.ctrl[SMT_CTL_PULSE];
    end

    // Bus decode; the slave never inserts wait states
    assign apbAcc  = psel && penable;
    assign badAddr = !(paddr == SMT_OFS_CTRL || paddr == SMT_OFS_TIMER
                       || paddr == SMT_OFS_STAT);
    // Byte-wide timer writes would tear the count, so they are refused
    assign badStrb = pwrite && paddr == SMT_OFS_TIMER && pstrb[1:0] != 2'b11;  // [R16]
    assign wrCtrl  = apbAcc && pwrite && paddr == SMT_OFS_CTRL;
    assign wrTimer = apbAcc && pwrite && paddr == SMT_OFS_TIMER && !badStrb;
    assign wrStat  = apbAcc && pwrite && paddr == SMT_OFS_STAT;
    assign pready  = 1'b1;
    assign pslverr = apbAcc && (badAddr || badStrb);
    assign prdata  = st.rdata;

    // Edges of the input pin
    assign inFall = st.prevIn && !timerInputPin;
    assign inRise = !st.prevIn && timerInputPin;

    // Internal count source from the prescalers
    always_comb begin
        unique case (src)                                    // [R10]
            SMT_SRC_DIV1:  intTick = 1'b1;
            SMT_SRC_DIV8:  intTick = st.preMain[2:0] == SMT_DIV8_LAST;
            SMT_SRC_DIV32: intTick = st.preMain == SMT_DIV32_LAST;
            SMT_SRC_SUB32: intTick = subClkTick && st.preSub == SMT_DIV32_LAST;
        endcase
    end

    // Event source and direction; direction is sampled per edge
    always_comb begin
        if (st.ctrl[SMT_CTL_TWOPH]) begin
            evTick  = inRise;                                // [R7]
            countUp = tmrOutPinIn;                           // [R7]
        end else begin
            unique case (evSrc)                              // [R5]
                SMT_EV_FALL: evTick = inFall;
                SMT_EV_RISE: evTick = inRise;
                default:     evTick = otherOvf;
            endcase
            // Read at the tick itself, so a change acts from the next edge
            countUp = st.ctrl[SMT_CTL_DIRPIN] ? tmrOutPinIn
                                              : st.ctrl[SMT_CTL_UP];   // [R24]
        end
    end

    // Gate check for timer mode
    always_comb begin
        unique case (gate)
            SMT_GATE_LOW:  gateOk = !timerInputPin;          // [R4]
            SMT_GATE_HIGH: gateOk = timerInputPin;           // [R22]
            default:       gateOk = 1'b1;
        endcase
    end

    // Start trigger for one-shot and PWM
    always_comb begin
        unique case (trig)                                   // [R8]
            SMT_TRIG_SW:  startTrig = wrCtrl && pwdata[SMT_CTL_SWTRIG];
            SMT_TRIG_PIN: startTrig = inFall;
            default:      startTrig = otherOvf;
        endcase
    end

    // PWM period end: fixed in 16-bit mode, low byte in 8-bit mode
    assign pwmTop = st.ctrl[SMT_CTL_PWM8] ? {8'h00, st.reload[7:0]} : SMT_PWM16_TOP;  // [R9]

    // Next-state logic of the whole channel
    always_comb begin
        next_st = st;
        irqEvt  = 1'b0;
        next_st.prevIn  = timerInputPin;
        next_st.preMain = st.preMain + 5'h01;
        if (subClkTick) begin
            next_st.preSub = st.preSub + 5'h01;
        end
        if (run) begin
            unique case (mode)
                SMT_MODE_TIMER: begin
                    // Down count; ratio is value plus one
                    if (intTick && gateOk) begin             // [R3] [R19] [R22]
                        if (st.counter == 16'h0000) begin
                            next_st.counter = st.reload;     // [R11] [R20]
                            irqEvt = 1'b1;                   // [R14] [R20]
                            if (pulseEn) begin
                                next_st.outLvl = !st.outLvl; // [R14]
                            end
                        end else begin
                            next_st.counter = st.counter - 16'h0001;   // [R19]
                        end
                    end
                end
                SMT_MODE_EVENT: begin
                    if (evTick && countUp) begin
                        // Up count overflows after FFFF minus value plus one
                        if (st.counter == SMT_CNT_MAX) begin             // [R12]
                            next_st.counter = st.ctrl[SMT_CTL_FREERUN]
                                              ? 16'h0000 : st.reload;   // [R6]
                            irqEvt = 1'b1;                               // [R14]
                        end else begin
                            next_st.counter = st.counter + 16'h0001;
                        end
                    end else if (evTick) begin
                        if (st.counter == 16'h0000) begin                // [R12]
                            next_st.counter = st.ctrl[SMT_CTL_FREERUN]
                                              ? SMT_CNT_MAX : st.reload; // [R6]
                            irqEvt = 1'b1;                               // [R20]
                        end else begin
                            next_st.counter = st.counter - 16'h0001;
                        end
                    end
                end
                SMT_MODE_ONESHOT: begin
                    if (startTrig && !st.active) begin
                        next_st.active  = 1'b1;              // [R8]
                        next_st.counter = st.reload;         // [R13]
                        next_st.outLvl  = pulseEn;
                    end else if (st.active && intTick) begin
                        // Ends after the programmed count of ticks, after one tick for a value of zero
                        if (st.counter <= 16'h0001) begin    // [R13]
                            next_st.active  = 1'b0;          // [R8]
                            next_st.counter = 16'h0000;
                            next_st.outLvl  = 1'b0;
                            irqEvt = 1'b1;                   // [R14]
                        end else begin
                            next_st.counter = st.counter - 16'h0001;
                        end
                    end
                end
                SMT_MODE_PWM: begin
                    if (startTrig && !st.active) begin
                        next_st.active  = 1'b1;              // [R9]
                        next_st.counter = 16'h0000;
                        next_st.outLvl  = pwmLevel(16'h0000, st.reload,
                                                   st.ctrl[SMT_CTL_PWM8]);
                    end else if (st.active && intTick) begin
                        // Period of top plus one ticks
                        if (st.counter == pwmTop) begin      // [R11]
                            next_st.counter = 16'h0000;
                            irqEvt = 1'b1;                   // [R14]
                        end else begin
                            next_st.counter = st.counter + 16'h0001;
                        end
                        next_st.outLvl = pwmLevel(next_st.counter, st.reload,
                                                  st.ctrl[SMT_CTL_PWM8]);  // [R9]
                    end
                end
            endcase
        end
        // Register writes
        if (wrCtrl) begin
            next_st.ctrl = pwdata[SMT_CTL_WIDTH-1:0];
        end
        if (wrTimer) begin
            next_st.reload = pwdata[15:0];                   // [R1] [R16]
            if (!run) begin
                next_st.counter = pwdata[15:0];              // [R16]
            end
        end
        // Stopping freezes the count and drops the output
        if (!next_st.ctrl[SMT_CTL_RUN]) begin                // [R21]
            next_st.outLvl = 1'b0;                           // [R23]
            next_st.active = 1'b0;
        end
        // Set wins over a clear in the same cycle
        if ((wrStat && pwdata[SMT_ST_IRQ]) || irqAck) begin
            next_st.irq = 1'b0;
        end
        if (irqEvt) begin
            next_st.irq = 1'b1;                              // [R20] [R25]
        end
        // Read data captured in the setup phase
        if (psel && !penable && !pwrite) begin
            next_st.rdata = 32'h0000_0000;
            if (paddr == SMT_OFS_CTRL) begin
                next_st.rdata[SMT_CTL_WIDTH-1:0] = st.ctrl;
            end else if (paddr == SMT_OFS_TIMER) begin
                next_st.rdata[15:0] = st.counter;            // [R15]
            end else if (paddr == SMT_OFS_STAT) begin
                next_st.rdata[SMT_ST_IRQ]    = st.irq;
                next_st.rdata[SMT_ST_OUT]    = st.outLvl;
                next_st.rdata[SMT_ST_ACTIVE] = st.active;
            end
        end
    end

    // State register
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            st <= '{ctrl: '0, counter: SMT_TIMER_RST, reload: SMT_TIMER_RST,
                    irq: 1'b0, outLvl: 1'b0, active: 1'b0, prevIn: 1'b0,
                    preMain: SMT_PRE_RST, preSub: SMT_PRE_RST, rdata: '0};
        end else begin
            st <= next_st;
        end
    end

    // Pin and request outputs; the pin turns input in event mode
    assign tmrOutPinOut = st.outLvl;
    assign tmrOutPinOeN = !(mode != SMT_MODE_EVENT
                            && (pulseEn || mode == SMT_MODE_PWM));  // [R18]
    assign irqReq       = st.irq;

    // Checks on the channel's own behaviour
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    property p_freeze;
        !run && !wrTimer |=> $stable(st.counter);
    endproperty
    a_freeze: assert property (p_freeze)    // [R21]
        else $error("counter moved while stopped");

    property p_reload;
        run && mode == SMT_MODE_TIMER && intTick && gateOk && st.counter == 16'h0000
            && !wrTimer |=> st.counter == $past(st.reload) && st.irq;
    endproperty
    a_reload: assert property (p_reload)    // [R20]
        else $error("underflow did not reload and request");

    property p_decrement;
        run && mode == SMT_MODE_TIMER && intTick && gateOk && st.counter != 16'h0000
            |=> st.counter == $past(st.counter) - 16'h0001;
    endproperty
    a_decrement: assert property (p_decrement)    // [R19]
        else $error("timer did not count down by one");

    property p_sticky;
        st.irq && !irqAck && !(wrStat && pwdata[SMT_ST_IRQ]) |=> st.irq;
    endproperty
    a_sticky: assert property (p_sticky)    // [R25]
        else $error("request bit dropped without clear");

    property p_gate_hold;
        run && mode == SMT_MODE_TIMER && gate == SMT_GATE_HIGH && !timerInputPin
            && !wrTimer |=> $stable(st.counter);
    endproperty
    a_gate_hold: assert property (p_gate_hold)    // [R22]
        else $error("gated counter moved with pin low");

    property p_out_low;
        $fell(run) |-> !tmrOutPinOut ##1 !tmrOutPinOut;
    endproperty
    a_out_low: assert property (p_out_low)    // [R23]
        else $error("output not low after stop");

    property p_wr_stopped;
        wrTimer && !run |=> st.counter == $past(pwdata[15:0]) && st.reload == st.counter;
    endproperty
    a_wr_stopped: assert property (p_wr_stopped)    // [R16]
        else $error("stopped write missed counter");

    property p_wr_running;
        wrTimer && run && mode == SMT_MODE_TIMER && !(intTick && gateOk)
            |=> st.reload == $past(pwdata[15:0]) && st.counter == $past(st.counter);
    endproperty
    a_wr_running: assert property (p_wr_running)    // [R16]
        else $error("running write touched counter");

    property p_event_input;
        mode == SMT_MODE_EVENT |-> tmrOutPinOeN;
    endproperty
    a_event_input: assert property (p_event_input)    // [R18]
        else $error("output pin driven in event mode");

    property p_oneshot_end;
        run && mode == SMT_MODE_ONESHOT && st.active && intTick && st.counter == 16'h0001
            |=> !st.active && st.irq && !tmrOutPinOut;
    endproperty
    a_oneshot_end: assert property (p_oneshot_end)    // [R8]
        else $error("one-shot did not stop at zero");

    // Main scenarios reached
    c_underflow: cover property (run && mode == SMT_MODE_TIMER && irqEvt);
    c_event_up:  cover property (run && mode == SMT_MODE_EVENT && evTick && countUp);
    c_oneshot:   cover property (run && mode == SMT_MODE_ONESHOT && irqEvt);
    c_pwm:       cover property (run && mode == SMT_MODE_PWM && $rose(st.outLvl));

endmodule

/* File: tb/smt_pins.sv */
/* Pin-side partner of the timer channel: input pin, secondary tick.
   Assumes pins synchronous to sys_clk, pull-up on the output pin. */
`timescale 1ns/1ps
module smt_pins (
    input  wire logic sys_clk,       // Main clock
    input  wire logic arst_n,        // Reset, active low
    input  wire logic inLvl,         // Wanted input pin level
    input  wire logic outLvl,        // Level the block drives
    input  wire logic outOeN,        // Block enable, low drives
    output logic      subClkTick,    // Secondary clock pulse
    output logic      timerInputPin, // Input pin
    output logic      tmrOutPinIn    // Resolved output pin
);
    logic [3:0] subDiv; // Secondary clock stand-in, 16x slower

    // Free divider, so the secondary tick is unrelated to bus traffic
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) subDiv <= 4'h0;
        else subDiv <= subDiv + 4'h1;
    end
    assign subClkTick = (subDiv == 4'hF);
    // Port left as input, level passes straight
    assign timerInputPin = inLvl;
    // Undriven pin floats to the pull-up level
    assign tmrOutPinIn = outOeN ? 1'b1 : outLvl;
endmodule

/* File: tb/tb_top.sv */
/* Register-level testbench of the timer channel.
   Assumes the APB slave answers at once and the pin partner model. */
`timescale 1ns/1ps
module tb_top;
    import smt_pkg::*;
    logic        sys_clk = 1'b0;  // Main clock
    logic        arst_n = 1'b0;   // Reset, active low
    logic        psel = 1'b0;     // APB select
    logic        penable = 1'b0;  // APB access phase
    logic        pwrite = 1'b0;   // APB direction
    logic [7:0]  paddr = 8'h00;   // APB address
    logic [31:0] pwdata = 32'h0;  // APB write data
    logic [31:0] prdata, rd, sv;  // Read data, captures
    logic        pready, pslverr, err, subClkTick, timerInputPin, tmrOutPinIn;
    logic        tmrOutPinOut, tmrOutPinOeN, irqReq;
    logic        inLvl = 1'b0;    // Input pin wish
    logic [3:0]  pstrb = 4'hF;    // APB byte strobes
    logic        irqAck = 1'b0;   // Interrupt acknowledge
    int          n_errors = 0;    // Mismatches
    int          checked = 0;     // Comparisons
    int          k;               // Measured cycles
    int          src;             // Source loop index

    always #20 sys_clk = ~sys_clk;

    smt_timer uut (.sys_clk(sys_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .subClkTick(subClkTick), .otherOvf(1'b0),
        .irqAck(irqAck), .timerInputPin(timerInputPin), .tmrOutPinIn(tmrOutPinIn),
        .tmrOutPinOut(tmrOutPinOut), .tmrOutPinOeN(tmrOutPinOeN), .irqReq(irqReq));
    smt_pins pins (.sys_clk(sys_clk), .arst_n(arst_n), .inLvl(inLvl), .outLvl(tmrOutPinOut),
        .outOeN(tmrOutPinOeN), .subClkTick(subClkTick), .timerInputPin(timerInputPin),
        .tmrOutPinIn(tmrOutPinIn));

    // One APB transfer, then one idle edge so psel is never set twice at once
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1) begin
            @(posedge sys_clk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Cycles between two toggles of the output pin, bounded
    task automatic period(output int n);
        logic v;
        for (int i = 0; i < 2; i++) begin
            n = 0;
            v = tmrOutPinOut;
            while (tmrOutPinOut === v && n < 5000) begin
                n++;
                @(posedge sys_clk);
            end
        end
    endtask

    // Rising then falling edges on the input pin, two cycles each
    task automatic pulses(input int n);
        repeat (n) begin
            inLvl <= 1'b1;
            repeat (2) @(posedge sys_clk);
            inLvl <= 1'b0;
            repeat (2) @(posedge sys_clk);
        end
    endtask

    task automatic wrap_up;
        if (n_errors == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // Watchdog, far beyond the few thousand cycles the tests need
    initial begin
        #2000000;
        n_errors++;
        wrap_up();
    end

    initial begin
        repeat (5) @(posedge sys_clk);
        arst_n <= 1'b1;
        @(posedge sys_clk);
        apb(1'b0, SMT_OFS_CTRL, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 8'h0C, 32'h0);
        chk({31'h0, err}, 32'h1);
        // Stopped write reaches the counter
        apb(1'b1, SMT_OFS_TIMER, 32'h1234);
        // Byte-wide timer write is refused and leaves the count alone
        pstrb <= 4'h1;
        apb(1'b1, SMT_OFS_TIMER, 32'h99);
        pstrb <= 4'hF;
        chk({31'h0, err}, 32'h1);
        apb(1'b0, SMT_OFS_TIMER, 32'h0);
        chk(rd, 32'h1234);
        // Reload 3, pulse output, every source: ratio 4 ticks per toggle
        apb(1'b1, SMT_OFS_TIMER, 32'h3);
        for (src = 0; src < 4; src++) begin
            apb(1'b1, SMT_OFS_CTRL, 32'h81 | (src << 3));
            period(k);
            chk(k, 4 * ((src == 0) ? 1 : (src == 1) ? 8 : (src == 2) ? 32 : 512));
        end
        chk({31'h0, irqReq}, 32'h1);
        apb(1'b1, SMT_OFS_CTRL, 32'h80);
        chk({31'h0, tmrOutPinOut}, 32'h0);
        apb(1'b0, SMT_OFS_TIMER, 32'h0);
        sv = rd;
        repeat (6) @(posedge sys_clk);
        apb(1'b0, SMT_OFS_TIMER, 32'h0);
        chk(rd, sv);
        chk({31'h0, irqReq}, 32'h1);
        apb(1'b1, SMT_OFS_STAT, 32'h1);
        chk({31'h0, irqReq}, 32'h0);
        // High gate: pin low holds, running write touches reload only
        apb(1'b1, SMT_OFS_TIMER, 32'h10);
        apb(1'b1, SMT_OFS_CTRL, 32'h61);
        repeat (8) @(posedge sys_clk);
        apb(1'b1, SMT_OFS_TIMER, 32'h55);
        apb(1'b0, SMT_OFS_TIMER, 32'h0);
        chk(rd, 32'h10);
        pulses(1);
        apb(1'b0, SMT_OFS_TIMER, 32'h0);
        chk(rd, 32'hE);
        // Low gate with pin low counts once before the read setup
        apb(1'b1, SMT_OFS_CTRL, 32'h41);
        apb(1'b0, SMT_OFS_TIMER, 32'h0);
        chk(rd, 32'hD);
        // Event mode, rising edges: down three, then up two
        apb(1'b1, SMT_OFS_CTRL, 32'h0);
        apb(1'b1, SMT_OFS_TIMER, 32'h5);
        apb(1'b1, SMT_OFS_CTRL, 32'h103);
        chk({31'h0, tmrOutPinOeN}, 32'h1);
        pulses(3);
        apb(1'b0, SMT_OFS_TIMER, 32'h0);
        chk(rd, 32'h2);
        apb(1'b1, SMT_OFS_CTRL, 32'h1103);
        pulses(2);
        apb(1'b0, SMT_OFS_TIMER, 32'h0);
        chk(rd, 32'h4);
        // One-shot of five ticks from a software trigger, then stop
        apb(1'b1, SMT_OFS_CTRL, 32'h0);
        apb(1'b1, SMT_OFS_TIMER, 32'h5);
        apb(1'b1, SMT_OFS_CTRL, 32'h85);
        apb(1'b1, SMT_OFS_CTRL, 32'h20085);
        apb(1'b0, SMT_OFS_STAT, 32'h0);
        chk(rd, 32'h6);
        apb(1'b0, SMT_OFS_STAT, 32'h0);
        chk(rd, 32'h6);
        apb(1'b0, SMT_OFS_STAT, 32'h0);
        chk(rd, 32'h1);
        irqAck <= 1'b1;
        @(posedge sys_clk);
        irqAck <= 1'b0;
        @(posedge sys_clk);
        chk({31'h0, irqReq}, 32'h0);
        // 8-bit PWM, top 3, high while phase below 2
        apb(1'b1, SMT_OFS_CTRL, 32'h0);
        apb(1'b1, SMT_OFS_TIMER, 32'h0203);
        apb(1'b1, SMT_OFS_CTRL, 32'h4007);
        apb(1'b1, SMT_OFS_CTRL, 32'h24007);
        period(k);
        chk(k, 2);
        wrap_up();
    end
endmodule
